// ===== core/rsspi_pkg.sv
// Constants shared by the relay switch serial slave.
package rsspi_pkg;
	// --------------------------------------------------
	// Frame layout
	// --------------------------------------------------
	localparam int FRAME_BITS = 8;
	localparam int CNT_W = 3;
	localparam int BIT_RW = 7;
	localparam int BIT_DIAGNOSIS_BANK_REQ = 1;
	localparam int BIT_BANK = 0;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 4;
	localparam int DATA_HI = 3;
	// --------------------------------------------------
	// Control bank addresses
	// --------------------------------------------------
	localparam logic [2:0] ADDR_INPUT_CTRL_PAIR01 = 3'h0;
	localparam logic [2:0] ADDR_INPUT_CTRL_PAIR23 = 3'h1;
	localparam logic [2:0] ADDR_INPUT_CTRL_PAIR45 = 3'h2;
	localparam logic [2:0] ADDR_INPUT_CTRL_PAIR67 = 3'h3;
	localparam logic [2:0] ADDR_DIAGNOSIS_BANK_CURRENT_LO = 3'h4;
	localparam logic [2:0] ADDR_DIAGNOSIS_BANK_CURRENT_HI = 3'h5;
	localparam logic [2:0] ADDR_COMMAND_BITS = 3'h6;
	localparam logic [2:0] ADDR_RESERVED_SLOT = 3'h7;
	// --------------------------------------------------
	// Command register fields
	// --------------------------------------------------
	localparam int CMD_CLEAR_LATCHED = 0;
	localparam int CMD_SOFT_RESET = 1;
	localparam int CMD_STANDBY = 2;
	localparam int CMD_WAKE = 3;
	// --------------------------------------------------
	// Reply words
	// --------------------------------------------------
	localparam int STD_AWAKE_BIT = 5;
	localparam int STD_LIMP_BIT = 4;
	localparam logic [1:0] TAG_DIAGNOSIS_BANK_REPLY = 2'h1;
	localparam logic TAG_CTRL_REPLY = 1'h1;
	// --------------------------------------------------
	// Reset values
	// --------------------------------------------------
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic TER_RESET = 1'h1;
	localparam logic [7:0] WORD_RESET = 8'h00;
	// Reply chosen for the next frame
	typedef enum {
		RSSPI_REPLY_STD,
		RSSPI_REPLY_CTRL,
		RSSPI_REPLY_DIAGNOSIS_BANK
	} rsspi_reply_type;
endpackage : rsspi_pkg

// ===== core/rsspi_slave.sv
// Serial slave of the eight channel relay switch.
//
// Notes on behaviour
// - Chip select high: ignore clock, float output
// - Sample falling, shift rising, MSB first
// - Select fall loads diagnosis into shifter
// - Before first rise, output is error OR input
// - Bad bit count sets error, drops command
// - Valid frame end transfers and decodes command
// - One bit per clock through 8-bit shifter
// - Bit 7 set writes data to address
// - Bit 7, bit 1 clear: register read
// - Bit 1 set: standard diagnosis request
// - Read reply comes in the next frame
// - Reply tags diagnosis or control bank
// - Standard reply: awake, limp, pair alerts
// - Error flag shows previous frame, set after reset
// - Six control, four diagnosis registers
// - Control registers zero on reset, standby
// - Command bits clear after frame or action
// - Clear flags bit held until valid frame
// - Reset restores interface and error state
// - Fault and open load flags per channel
// - Diagnosis flags latched until clear command
`timescale 1ns/10ps
`default_nettype none
module rsspi_slave #(
	parameter int CHANNELS = 8
) (
	// System clock and reset
	input wire logic clock,
	input wire logic srst,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so_out,
	output logic so_oe,
	// Power stage status
	input wire logic [CHANNELS-1:0] fault_event,
	input wire logic [CHANNELS-1:0] open_load_event,
	input wire logic awake_flag,
	input wire logic limp_home_flag,
	// Control outputs
	output logic [2*CHANNELS-1:0] channel_input_select,
	output logic [CHANNELS-1:0] diagnosis_bank_current_enable,
	output logic clear_latched_flags,
	output logic standby_cmd,
	output logic soft_reset_cmd,
	output logic wake_cmd
);
	// --------------------------------------------------
	// Link domain
	// --------------------------------------------------
	// Words below are written by the system clock only
	// while select is high and the serial clock is
	// still, so the link reads them as static values.
	// Counter width must be known before the counter itself
	localparam int CNT_W_L = rsspi_pkg::CNT_W;
	logic [7:0] tx_word_reg;
	logic ter_reg;
	logic frame_tag_reg;
	logic [7:0] shift_reg;
	logic [CNT_W_L-1:0] bit_cnt_reg;
	logic fall_tag_reg;
	logic rise_tag_reg;
	logic so_bit_reg;
	logic fall_new;
	logic rise_new;
	logic [7:0] shift_base;

	// New frame until the link edge has seen this tag.
	// The tag only advances after a frame with edges, so an
	// empty frame cannot make a later frame look old.
	assign fall_new = (fall_tag_reg != frame_tag_reg);
	assign rise_new = (rise_tag_reg != frame_tag_reg);
	// First falling edge starts from the loaded reply
	assign shift_base = fall_new ? tx_word_reg : shift_reg;

	// Sample input on the falling clock edge
	always_ff @(negedge sclk or posedge srst) begin
		if (srst) begin
			shift_reg <= rsspi_pkg::WORD_RESET;
			bit_cnt_reg <= '0;
			fall_tag_reg <= 1'b1;
		end else if (!cs_n) begin
			// MSB leaves, input bit enters at the bottom
			shift_reg <= {shift_base[6:0], si};
			fall_tag_reg <= frame_tag_reg;
			if (fall_new) begin
				bit_cnt_reg <= CNT_W_L'(1);
			end else begin
				// Counter wraps, so it counts modulo eight
				bit_cnt_reg <= bit_cnt_reg + CNT_W_L'(1);
			end
		end
	end

	// Drive output on the rising clock edge
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			so_bit_reg <= 1'b0;
			rise_tag_reg <= 1'b1;
		end else if (!cs_n) begin
			rise_tag_reg <= frame_tag_reg;
			if (rise_new) begin
				so_bit_reg <= tx_word_reg[7];
			end else begin
				so_bit_reg <= shift_reg[7];
			end
		end
	end

	// Pin drivers
	// These stay combinational: the error preview must
	// follow the input pin at once for daisy chains, and
	// the float must track select without a clock.
	assign so_oe = !cs_n;
	assign so_out = rise_new ? (ter_reg | si) : so_bit_reg;

	// --------------------------------------------------
	// Select synchroniser
	// --------------------------------------------------
	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_prev_reg;
	logic frame_end;

	// Two stages before any system clock logic looks at select.
	// Costs two or three cycles of decode latency, which the
	// gap between frames easily covers.
	always_ff @(posedge clock) begin
		cs_meta_reg <= cs_n;
		cs_sync_reg <= cs_meta_reg;
	end

	// Edge detector on the settled copy
	always_ff @(posedge clock) begin
		if (srst) begin
			cs_prev_reg <= 1'b1;
		end else begin
			cs_prev_reg <= cs_sync_reg;
		end
	end

	assign frame_end = cs_sync_reg && !cs_prev_reg;

	// --------------------------------------------------
	// Frame check and decode
	// --------------------------------------------------
	logic frame_ok;
	logic [7:0] rx_word;
	logic is_write;
	logic is_read;
	logic [2:0] rx_addr;
	logic [3:0] rx_data;
	logic ctrl_wr;
	logic cmd_wr;
	logic clear_all;

	// A frame without edges leaves the tags unequal
	assign frame_ok = frame_end && (fall_tag_reg == frame_tag_reg)
		&& (bit_cnt_reg == '0);
	assign rx_word = shift_reg;
	assign is_write = rx_word[rsspi_pkg::BIT_RW];
	assign is_read = !rx_word[rsspi_pkg::BIT_RW]
		&& !rx_word[rsspi_pkg::BIT_DIAGNOSIS_BANK_REQ];
	assign rx_addr = rx_word[rsspi_pkg::ADDR_HI:rsspi_pkg::ADDR_LO];
	assign rx_data = rx_word[rsspi_pkg::DATA_HI:0];
	assign ctrl_wr = frame_ok && is_write;
	assign cmd_wr = ctrl_wr && (rx_addr == rsspi_pkg::ADDR_COMMAND_BITS);
	// Standby and soft reset both empty the control bank
	assign clear_all = cmd_wr && (rx_data[rsspi_pkg::CMD_STANDBY]
		|| rx_data[rsspi_pkg::CMD_SOFT_RESET]);

	// Frame tag flips once per ended frame that saw clock
	// edges. A frame without any edge leaves the link flops
	// untouched; flipping then would bring the tags back
	// into step and the next frame would skip its reply
	// load and its error preview.
	always_ff @(posedge clock) begin
		if (srst) begin
			frame_tag_reg <= 1'b0;
		end else if (frame_end && (fall_tag_reg == frame_tag_reg)) begin
			frame_tag_reg <= !frame_tag_reg;
		end
	end

	// Error flag reflects the previous frame only
	always_ff @(posedge clock) begin
		if (srst) begin
			ter_reg <= rsspi_pkg::TER_RESET;
		end else if (frame_end) begin
			ter_reg <= !frame_ok;
		end
	end

	// --------------------------------------------------
	// Control bank
	// --------------------------------------------------
	logic [3:0] ctrl_reg [0:5];
	logic [3:0] ctrl_next [0:5];

	// One register per address, all zero on clear.
	// The unused slot holds no storage; the command slot keeps
	// only the clear flags bit, which reads back.
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_ctrl
			always_comb begin
				ctrl_next[gi] = ctrl_reg[gi];
				if (clear_all) begin
					ctrl_next[gi] = rsspi_pkg::CTRL_RESET;
				end else if (ctrl_wr && rx_addr == 3'(gi)) begin
					ctrl_next[gi] = rx_data;
				end
			end
			always_ff @(posedge clock) begin
				if (srst) begin
					ctrl_reg[gi] <= rsspi_pkg::CTRL_RESET;
				end else begin
					ctrl_reg[gi] <= ctrl_next[gi];
				end
			end
		end
	endgenerate

	// Control outputs straight from the bank
	always_ff @(posedge clock) begin
		if (srst) begin
			channel_input_select <= '0;
			diagnosis_bank_current_enable <= '0;
		end else begin
			channel_input_select <= {ctrl_next[3], ctrl_next[2],
				ctrl_next[1], ctrl_next[0]};
			diagnosis_bank_current_enable <= {ctrl_next[5], ctrl_next[4]};
		end
	end

	// --------------------------------------------------
	// Command bits
	// --------------------------------------------------
	logic clear_exec;

	// Clear bit lives until a later frame checks out
	always_ff @(posedge clock) begin
		if (srst) begin
			clear_latched_flags <= 1'b0;
		end else if (cmd_wr) begin
			clear_latched_flags <= rx_data[rsspi_pkg::CMD_CLEAR_LATCHED];
		end else if (frame_ok) begin
			clear_latched_flags <= 1'b0;
		end
	end

	assign clear_exec = cmd_wr && rx_data[rsspi_pkg::CMD_CLEAR_LATCHED];

	// Other command bits act once and never persist
	always_ff @(posedge clock) begin
		if (srst) begin
			standby_cmd <= 1'b0;
			soft_reset_cmd <= 1'b0;
			wake_cmd <= 1'b0;
		end else begin
			standby_cmd <= cmd_wr && rx_data[rsspi_pkg::CMD_STANDBY];
			soft_reset_cmd <= cmd_wr
				&& rx_data[rsspi_pkg::CMD_SOFT_RESET];
			wake_cmd <= cmd_wr && rx_data[rsspi_pkg::CMD_WAKE];
		end
	end

	// --------------------------------------------------
	// Diagnosis bank
	// --------------------------------------------------
	logic [CHANNELS-1:0] fault_reg;
	logic [CHANNELS-1:0] open_load_reg;
	logic [3:0] diagnosis_bank_word [0:3];
	logic [3:0] pair_alert;

	// Sticky flags; a new event beats the clear
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_flag
			always_ff @(posedge clock) begin
				if (srst) begin
					fault_reg[gi] <= 1'b0;
					open_load_reg[gi] <= 1'b0;
				end else begin
					fault_reg[gi] <= fault_event[gi]
						|| (fault_reg[gi] && !clear_exec);
					open_load_reg[gi] <= open_load_event[gi]
						|| (open_load_reg[gi] && !clear_exec);
				end
			end
		end
		// Each word holds one channel pair
		for (gi = 0; gi < 4; gi++) begin : g_pair
			assign diagnosis_bank_word[gi] = {open_load_reg[2*gi+1],
				fault_reg[2*gi+1], open_load_reg[2*gi],
				fault_reg[2*gi]};
			assign pair_alert[gi] = |diagnosis_bank_word[gi];
		end
	endgenerate

	// --------------------------------------------------
	// Reply selection
	// --------------------------------------------------
	rsspi_pkg::rsspi_reply_type reply_reg;
	logic [2:0] reply_addr_reg;
	logic [3:0] ctrl_read;
	logic [7:0] tx_next;

	// Remember what the next frame must carry.
	// A dropped frame falls back to the standard reply, so a
	// broken read request never returns stale bank data.
	always_ff @(posedge clock) begin
		if (srst) begin
			reply_reg <= rsspi_pkg::RSSPI_REPLY_STD;
			reply_addr_reg <= '0;
		end else if (frame_end) begin
			reply_addr_reg <= rx_addr;
			if (frame_ok && is_read) begin
				if (rx_word[rsspi_pkg::BIT_BANK]) begin
					reply_reg <= rsspi_pkg::RSSPI_REPLY_DIAGNOSIS_BANK;
				end else begin
					reply_reg <= rsspi_pkg::RSSPI_REPLY_CTRL;
				end
			end else begin
				reply_reg <= rsspi_pkg::RSSPI_REPLY_STD;
			end
		end
	end

	// Control read-back; the unused slot is zero
	always_comb begin
		ctrl_read = 4'h0;
		if (reply_addr_reg == rsspi_pkg::ADDR_COMMAND_BITS) begin
			ctrl_read = {3'h0, clear_latched_flags};
		end else if (reply_addr_reg != rsspi_pkg::ADDR_RESERVED_SLOT) begin
			ctrl_read = ctrl_reg[reply_addr_reg];
		end
	end

	// Word to shift out during the coming frame
	always_comb begin
		case (reply_reg)
			rsspi_pkg::RSSPI_REPLY_CTRL: begin
				tx_next = {rsspi_pkg::TAG_CTRL_REPLY, reply_addr_reg,
					ctrl_read};
			end
			rsspi_pkg::RSSPI_REPLY_DIAGNOSIS_BANK: begin
				tx_next = {rsspi_pkg::TAG_DIAGNOSIS_BANK_REPLY,
					reply_addr_reg[1:0],
					diagnosis_bank_word[reply_addr_reg[1:0]]};
			end
			default: begin
				tx_next = {2'h0, awake_flag, limp_home_flag,
					pair_alert};
			end
		endcase
	end

	// Loaded only while select is high and stable.
	// The link reads this word without a synchroniser, so it
	// must never move while a frame may be starting.
	always_ff @(posedge clock) begin
		if (srst) begin
			tx_word_reg <= rsspi_pkg::WORD_RESET;
		end else if (cs_sync_reg && cs_prev_reg) begin
			tx_word_reg <= tx_next;
		end
	end
endmodule : rsspi_slave
`default_nettype wire

// ===== sim/rsspi_slave_assertions.sv
// Port checks for the relay switch serial slave.
`timescale 1ns/10ps
`default_nettype none
module rsspi_slave_assertions #(
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Link pins
	input wire logic cs_n,
	input wire logic so_oe,
	// Control outputs
	input wire logic [2*CHANNELS-1:0] channel_input_select,
	input wire logic [CHANNELS-1:0] diagnosis_bank_current_enable,
	input wire logic clear_latched_flags,
	input wire logic standby_cmd,
	input wire logic soft_reset_cmd,
	input wire logic wake_cmd
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// Cycles with select low; decode never lands this deep in a frame
	logic [2:0] low_reg;
	always_ff @(posedge clock) begin
		if (srst || cs_n) begin
			low_reg <= 3'h0;
		end else if (low_reg != 3'h7) begin
			low_reg <= low_reg + 3'h1;
		end
	end
	property p_oe; so_oe == !cs_n; endproperty
	a_oe: assert property (p_oe)
		else $error("output enable not tracking select");
	property p_hold;
		low_reg >= 3'h4 |->
			$stable(channel_input_select) && $stable(diagnosis_bank_current_enable);
	endproperty
	a_hold: assert property (p_hold)
		else $error("control changed inside a frame");
	property p_chg; $changed(diagnosis_bank_current_enable) |-> cs_n && $past(cs_n);
	endproperty
	a_chg: assert property (p_chg)
		else $error("enable changed before select rose");
	property p_clr; $changed(clear_latched_flags) |-> cs_n; endproperty
	a_clr: assert property (p_clr)
		else $error("clear flag moved inside a frame");
	property p_stb; standby_cmd |=> !standby_cmd &&
		channel_input_select == '0 && diagnosis_bank_current_enable == '0;
	endproperty
	a_stb: assert property (p_stb)
		else $error("standby pulse wrong");
	property p_rst; soft_reset_cmd |=> !soft_reset_cmd &&
		channel_input_select == '0 && diagnosis_bank_current_enable == '0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("soft reset pulse wrong");
	property p_wake; wake_cmd |=> !wake_cmd; endproperty
	a_wake: assert property (p_wake)
		else $error("wake pulse too long");
	property p_end;
		standby_cmd || soft_reset_cmd || wake_cmd |-> cs_n && low_reg == 3'h0;
	endproperty
	a_end: assert property (p_end)
		else $error("command pulse inside a frame");
endmodule : rsspi_slave_assertions
bind rsspi_slave rsspi_slave_assertions #(.CHANNELS(CHANNELS)) u_chk (
	.clock, .srst, .cs_n, .so_oe, .channel_input_select,
	.diagnosis_bank_current_enable, .clear_latched_flags, .standby_cmd,
	.soft_reset_cmd, .wake_cmd);
`default_nettype wire

// ===== sim/rsspi_master.sv
// Serial master model for the relay switch slave.
`timescale 1ns/10ps
`default_nettype none
module rsspi_master (
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic si,
	// Reply pin
	input wire logic so_out
);
	// Released pins rest at their pull levels
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// One frame msb first; 160 ns clock runs only while selected
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [15:0] rx, output logic ter, output logic orr);
		rx = 16'h0000;
		cs_n = 1'b0;
		#100 ter = so_out;
		si = 1'b1;
		#100 orr = so_out;
		#80;
		for (int i = n - 1; i >= 0; i--) begin
			si = tx[i];
			#40 sclk = 1'b1;
			#80 rx = {rx[14:0], so_out};
			sclk = 1'b0;
			#40;
		end
		#250 cs_n = 1'b1;
		si = 1'b0;
		#600;
	endtask : xfer
endmodule : rsspi_master
`default_nettype wire

// ===== sim/rsspi_slave_tb_top.sv
// Self-checking bench for the relay switch serial slave.
`timescale 1ns/10ps
`default_nettype none
module rsspi_slave_tb_top;
	logic clock, srst, sclk, cs_n, si, so_out, so_oe, ter, orr;
	logic [7:0] fault_event, open_load_event, diagnosis_bank_current_enable;
	logic awake_flag, limp_home_flag, clear_latched_flags;
	logic standby_cmd, soft_reset_cmd, wake_cmd;
	logic [15:0] channel_input_select, rx;
	logic [2:0] seen;
	int err_total = 0;
	int n_tests = 0;
	// 20 MHz system clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	rsspi_slave dut (.clock, .srst, .sclk, .cs_n, .si, .so_out, .so_oe,
		.fault_event, .open_load_event, .awake_flag, .limp_home_flag,
		.channel_input_select, .diagnosis_bank_current_enable, .clear_latched_flags,
		.standby_cmd, .soft_reset_cmd, .wake_cmd);
	rsspi_master master (.sclk, .cs_n, .si, .so_out);
	// One-cycle pulses would be missed by a late look
	always @(posedge clock) begin
		seen <= seen | {wake_cmd, standby_cmd, soft_reset_cmd};
	end
	task automatic chk(string w, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", w, e, g);
			err_total++;
		end
	endtask : chk
	// Frame with error flag and pre-clock output checked
	task automatic frm(logic [15:0] tx, int n, logic t);
		master.xfer(tx, n, rx, ter, orr);
		chk("error flag", {15'h0, t}, {15'h0, ter});
		chk("pre-clock so", 16'h1, {15'h0, orr});
	endtask : frm
	task automatic s_after_reset;
		frm(16'h0002, 8, 1'b1);
		chk("idle reply", 16'h0000, rx);
		chk("select", 16'h0000, channel_input_select);
	endtask : s_after_reset
	task automatic s_write_read;
		for (int a = 0; a < 6; a++) begin
			frm({8'h00, 1'b1, a[2:0], 4'(a + 5)}, 8, 1'b0);
		end
		frm(16'h00FF, 8, 1'b0);
		chk("select", 16'h8765, channel_input_select);
		chk("enable", 16'h00A9, {8'h00, diagnosis_bank_current_enable});
		for (int a = 0; a < 8; a++) begin
			frm({8'h00, 1'b0, a[2:0], 4'h0}, 8, 1'b0);
			if (a > 0) begin
				chk("read", {9'h001, 3'(a - 1), 4'(a < 7 ? a + 4 : 0)}, rx);
			end
		end
		frm(16'h0002, 8, 1'b0);
		chk("read unused", 16'h00F0, rx);
	endtask : s_write_read
	task automatic s_bad_count;
		int ns[3] = '{0, 5, 12};
		foreach (ns[i]) begin
			frm(16'h008F, ns[i], 1'b0);
			frm(16'h0002, 8, 1'b1);
		end
		chk("dropped", 16'h5, {12'h0, channel_input_select[3:0]});
		frm(16'h8F02, 16, 1'b0);
		chk("chain", 16'h8F, {8'h00, rx[7:0]});
		chk("dropped", 16'h5, {12'h0, channel_input_select[3:0]});
	endtask : s_bad_count
	task automatic s_diagnosis_bank;
		@(negedge clock);
		fault_event = 8'h01;
		open_load_event = 8'h80;
		awake_flag = 1'b1;
		limp_home_flag = 1'b1;
		@(negedge clock);
		fault_event = 8'h00;
		open_load_event = 8'h00;
		frm(16'h0002, 8, 1'b0);
		frm(16'h0001, 8, 1'b0);
		chk("standard", 16'h0039, rx);
		frm(16'h0031, 8, 1'b0);
		chk("diagnosis_bank 0", 16'h0041, rx);
		frm(16'h00E1, 8, 1'b0);
		chk("diagnosis_bank 3", 16'h0078, rx);
		chk("clear", 16'h1, {15'h0, clear_latched_flags});
		frm(16'h008F, 3, 1'b0);
		chk("clear", 16'h1, {15'h0, clear_latched_flags});
		frm(16'h0002, 8, 1'b1);
		chk("clear", 16'h0, {15'h0, clear_latched_flags});
		chk("cleared", 16'h0030, rx);
	endtask : s_diagnosis_bank
	task automatic s_cmds;
		for (int b = 1; b < 4; b++) begin
			frm(16'h0083, 8, 1'b0);
			@(negedge clock);
			seen = 3'h0;
			frm({8'h00, 4'hE, 4'(1 << b)}, 8, 1'b0);
			chk("pulses", 16'(1 << (b - 1)), {13'h0, seen});
			chk("regs", b == 3 ? 16'h3 : 16'h0, channel_input_select);
		end
		chk("enable", 16'h0000, {8'h00, diagnosis_bank_current_enable});
		frm(16'h0060, 8, 1'b0);
		frm(16'h0002, 8, 1'b0);
		chk("command", 16'h00E0, rx);
	endtask : s_cmds
	task automatic test_done;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	// Reset for three cycles, then the scenarios
	initial begin
		srst = 1'b1;
		fault_event = 8'h00;
		open_load_event = 8'h00;
		awake_flag = 1'b0;
		limp_home_flag = 1'b0;
		seen = 3'h0;
		repeat (3) @(negedge clock);
		srst = 1'b0;
		repeat (4) @(negedge clock);
		s_after_reset();
		s_write_read();
		s_bad_count();
		s_diagnosis_bank();
		s_cmds();
		test_done();
	end
	// Watchdog well past the roughly 100 us of traffic
	initial begin
		#500000;
		err_total++;
		test_done();
	end
endmodule : rsspi_slave_tb_top
`default_nettype wire
